// File: rtl/sarseq_pkg.sv
/*
  Shared constants and types for the converter sequencer: register indices,
  field layouts, reset values, phase states and timing figures.
  Assumes a 25 MHz system clock and a 16-bit APB byte address.
*/
package sarseq_pkg;

  // System clock period and the analog minimum times, in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;
  localparam int SAMPLE_MIN_NS = 1000;
  localparam int SETTLE_MIN_NS = 500;
  // Least times round up to whole system clock cycles.
  localparam int SAMPLE_MIN_CYC = (SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_MIN_CYC = (SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Conversion length in converter clock ticks, and the index of the last one.
  localparam int CONV_TICKS = 13;
  localparam logic [3:0] CONV_LAST = 4'(CONV_TICKS - 1);
  localparam int RES_W = 10;
  localparam int ADDR_W = 16;

  // Register indices; the byte address is four times the index.
  localparam logic [13:0] IDX_CTRL = 14'h0F70;
  localparam logic [13:0] IDX_HIGH = 14'h0F72;
  localparam logic [13:0] IDX_LOW = 14'h0F73;
  localparam logic [13:0] IDX_SETTLE = 14'h0F74;
  localparam logic [13:0] IDX_SAMPLE = 14'h0F75;
  localparam logic [13:0] IDX_PRESC = 14'h0F76;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] SETTLE_RST = 4'hF;
  localparam logic [5:0] SAMPLE_RST = 6'h3F;
  localparam logic [2:0] PRESC_RST = 3'h0;

  // Layout of converter_control_0.
  typedef struct packed {
    logic start;
    logic rsv6;
    logic internalRefSelect;
    logic converterEnable;
    logic rsv3;
    logic [2:0] inputChannelSelect;
  } sarseq_ctrl_type;

  // Layout of the low three bits of clock_prescale_reg.
  typedef struct packed {
    logic divideByEight;
    logic divideByFour;
    logic divideByTwo;
  } sarseq_presc_type;

  // Controls handed to the analog converter core.
  typedef struct packed {
    logic referenceBuffer;
    logic converterEnable;
    logic [2:0] inputChannelSelect;
    logic sampleOn;
    logic holdOn;
    logic convertOn;
    logic conversionClockTick;
  } sarseq_ana_type;

  // Measurement phases, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_SETTLE = 4'h4,
    ST_CONV = 4'h8
  } sarseq_state_type;

endpackage : sarseq_pkg

// File: rtl/sarseq_prescale.sv
/*
  Converter clock prescaler: emits a one-cycle tick every 1, 2, 4 or 8
  system clocks while run is high.
  Assumes run and divSel come from logic on the same clock.
*/
`timescale 1ns/1ns
module sarseq_prescale #(
  parameter int CNT_W = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire sarseq_pkg::sarseq_presc_type divSel,
  output logic tick
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] lastCnt;

  // Divide-by-eight wins over four, four over two; none set means undivided.
  assign lastCnt = divSel.divideByEight ? CNT_W'(7) :
                   divSel.divideByFour ? CNT_W'(3) :
                   divSel.divideByTwo ? CNT_W'(1) : CNT_W'(0);
  assign tick = run && (cnt_r == lastCnt);

  // The count restarts with every run so the first tick is a full period away.
  always_ff @(posedge clk) begin
    if (!rstn || !run || tick) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

endmodule : sarseq_prescale

// File: rtl/sar_adc_sequencer.sv
/*
  Converter sequencer: APB register file, sample / settle / convert phase
  machine and result capture for an eight-input 10-bit SAR converter.
  Assumes the analog core holds convResult steady at the end of a
  conversion, and that APB comes from logic on clk.
*/
// Implementation choice: the APB interface to the registers.
// Notes on behaviour
// - Result is a 10-bit unsigned code.
// - Three-bit field picks one of eight inputs.
// - Writing start one begins; zero does nothing.
// - Start bit reads one while busy.
// - Start during conversion aborts and restarts.
// - Sampling phase lasts programmed system clocks.
// - Settling phase lasts programmed system clocks.
// - Conversion takes thirteen converter clock ticks.
// - Interrupt request on every completion.
// - Disabling never withdraws an issued request.
// - Bit five selects internal reference buffer.
// - Bit four enables the converter.
// - High register shows upper eight bits.
// - High read latches matching low bits.
// - Results hold until next completion.
// - Low bits in 7:6, rest zero.
// - Four-bit settle field, reset all ones.
// - Six-bit sample field, reset all ones.
// - Prescale divides by eight, four, two.
`timescale 1ns/1ns
module sar_adc_sequencer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sarseq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [sarseq_pkg::RES_W-1:0] convResult,
  output sarseq_pkg::sarseq_ana_type anaCtl,
  output logic convDoneIrq
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Register state.
  logic refSel_r;
  logic enable_r;
  logic [2:0] chan_r;
  logic [3:0] settle_r;
  logic [5:0] sample_r;
  sarseq_pkg::sarseq_presc_type presc_r;
  logic [sarseq_pkg::RES_W-1:0] result_r;
  logic [1:0] low_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic convTick_r;

  // Phase machine state.
  sarseq_pkg::sarseq_state_type state_r;
  sarseq_pkg::sarseq_state_type state_nxt;
  logic [5:0] phase_r;
  logic [5:0] phase_nxt;
  logic [3:0] tickCnt_r;
  logic done;
  logic tick;
  logic busy;

  // Result pins, two stages deep.
  logic [sarseq_pkg::RES_W-1:0] syncA_r;
  logic [sarseq_pkg::RES_W-1:0] syncB_r;

  // APB decode.
  logic [13:0] regIdx;
  logic selCtrl;
  logic selHigh;
  logic selLow;
  logic selSettle;
  logic selSample;
  logic selPresc;
  logic hitAny;
  logic setupPh;
  logic wrAcc;
  logic rdAcc;
  logic ctrlWr;
  logic startReq;
  logic disableWr;
  logic [7:0] rdMux;
  logic [5:0] sampleLen;
  logic [5:0] settleLen;
  sarseq_pkg::sarseq_ctrl_type wrCtrl;

  // The byte address carries the register index in its upper bits.
  assign regIdx = paddr[sarseq_pkg::ADDR_W-1:2];
  assign selCtrl = regIdx == sarseq_pkg::IDX_CTRL;
  assign selHigh = regIdx == sarseq_pkg::IDX_HIGH;
  assign selLow = regIdx == sarseq_pkg::IDX_LOW;
  assign selSettle = regIdx == sarseq_pkg::IDX_SETTLE;
  assign selSample = regIdx == sarseq_pkg::IDX_SAMPLE;
  assign selPresc = regIdx == sarseq_pkg::IDX_PRESC;
  assign hitAny = selCtrl | selHigh | selLow | selSettle | selSample | selPresc;

  // Every access completes in its first access cycle; unmapped ones error.
  assign setupPh = psel & ~penable;
  assign wrAcc = psel & penable & pwrite;
  assign rdAcc = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hitAny;
  assign prdata = {24'h000000, rdata_r};

  // Control write decode; a start only counts with the enable bit set.
  assign wrCtrl = pwdata[7:0];
  assign ctrlWr = wrAcc & selCtrl;
  assign startReq = ctrlWr & wrCtrl.start & wrCtrl.converterEnable;
  assign disableWr = ctrlWr & ~wrCtrl.converterEnable;
  assign busy = state_r != sarseq_pkg::ST_IDLE;

  // A programmed length of zero still gives one cycle, so the phase ends.
  assign sampleLen = (sample_r == 6'h00) ? 6'h01 : sample_r;
  assign settleLen = (settle_r == 4'h0) ? 6'h01 : {2'h0, settle_r};

  // Read data is chosen in the setup cycle and registered for the access.
  assign rdMux = selCtrl ? {busy, 1'b0, refSel_r, enable_r, 1'b0, chan_r} :
                 selHigh ? result_r[9:2] :
                 selLow ? {low_r, 6'h00} :
                 selSettle ? {4'h0, settle_r} :
                 selSample ? {2'h0, sample_r} :
                 selPresc ? {5'h00, presc_r} : 8'h00;

  // Converter core controls all come straight from flip-flops.
  assign anaCtl.referenceBuffer = refSel_r;
  assign anaCtl.converterEnable = enable_r;
  assign anaCtl.inputChannelSelect = chan_r;
  assign anaCtl.sampleOn = state_r[1];
  assign anaCtl.holdOn = state_r[2];
  assign anaCtl.convertOn = state_r[3];
  assign anaCtl.conversionClockTick = convTick_r;
  assign convDoneIrq = irq_r;

  // Converter clock prescaler, running only during conversion.
  sarseq_prescale #(
    .CNT_W(3)
  ) uPresc (
    .clk(clk),
    .rstn(rstn),
    .run(state_r == sarseq_pkg::ST_CONV),
    .divSel(presc_r),
    .tick(tick)
  );

  // Phase sequencing. A new start overrides everything, which aborts a
  // running conversion; a disable drops back to idle without a result.
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    done = 1'b0;
    case (state_r)
      sarseq_pkg::ST_IDLE: begin
        phase_nxt = 6'h00;
      end
      sarseq_pkg::ST_SAMPLE: begin
        if (phase_r <= 6'h01) begin
          state_nxt = sarseq_pkg::ST_SETTLE;
          phase_nxt = settleLen;
        end else begin
          phase_nxt = phase_r - 6'h01;
        end
      end
      sarseq_pkg::ST_SETTLE: begin
        if (phase_r <= 6'h01) begin
          state_nxt = sarseq_pkg::ST_CONV;
          phase_nxt = 6'h00;
        end else begin
          phase_nxt = phase_r - 6'h01;
        end
      end
      sarseq_pkg::ST_CONV: begin
        if (tick && tickCnt_r == sarseq_pkg::CONV_LAST) begin
          state_nxt = sarseq_pkg::ST_IDLE;
          done = 1'b1;
        end
      end
      default: begin
        state_nxt = sarseq_pkg::ST_IDLE;
        phase_nxt = 6'h00;
      end
    endcase
    if (startReq) begin
      state_nxt = sarseq_pkg::ST_SAMPLE;
      phase_nxt = sampleLen;
      done = 1'b0;
    end else if (disableWr) begin
      state_nxt = sarseq_pkg::ST_IDLE;
      done = 1'b0;
    end
  end

  // Phase state registers.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= sarseq_pkg::ST_IDLE;
      phase_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
    end
  end

  // Converter clock ticks seen in the current conversion.
  always_ff @(posedge clk) begin
    if (!rstn || state_r != sarseq_pkg::ST_CONV || startReq) begin
      tickCnt_r <= 4'h0;
      convTick_r <= 1'b0;
    end else begin
      tickCnt_r <= tick ? tickCnt_r + 4'h1 : tickCnt_r;
      convTick_r <= tick;
    end
  end

  // Result word from the analog core. It is static when sampled at the end
  // of a conversion, so the two stages only guard against metastability.
  always_ff @(posedge clk) begin
    syncA_r <= convResult;
    syncB_r <= syncA_r;
  end

  // Control, timing and prescale fields written by software.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {refSel_r, enable_r, chan_r} <= {sarseq_pkg::CTRL_RST[5:4], sarseq_pkg::CTRL_RST[2:0]};
      settle_r <= sarseq_pkg::SETTLE_RST;
      sample_r <= sarseq_pkg::SAMPLE_RST;
      presc_r <= sarseq_pkg::PRESC_RST;
    end else if (wrAcc) begin
      if (selCtrl) begin
        refSel_r <= wrCtrl.internalRefSelect;
        enable_r <= wrCtrl.converterEnable;
        chan_r <= wrCtrl.inputChannelSelect;
      end
      if (selSettle) begin
        settle_r <= pwdata[3:0];
      end
      if (selSample) begin
        sample_r <= pwdata[5:0];
      end
      if (selPresc) begin
        presc_r <= pwdata[2:0];
      end
    end
  end

  // Completion stores the result and pulses the request on the same edge
  // that returns the machine to idle. Disabling touches neither, so a
  // request already handed on stays with the interrupt controller.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= done;
      if (done) begin
        result_r <= syncB_r;
      end
    end
  end

  // A high-byte read freezes the low bits in its setup cycle, with the byte it
  // returns, so a low read pairs with it even if a conversion ends meanwhile.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_r <= 2'h0;
      rdata_r <= 8'h00;
    end else begin
      if (setupPh && !pwrite && selHigh) begin
        low_r <= result_r[1:0];
      end
      if (setupPh) begin
        rdata_r <= rdMux;
      end
    end
  end

  // Helper logic for the checks below: cycles spent in the current phase
  // and the lengths that were in force when each phase began.
  logic [7:0] dwell_r;
  logic [5:0] lenSample_r;
  logic [5:0] lenSettle_r;
  logic [7:0] convCycles;

  always_ff @(posedge clk) begin
    if (!rstn || startReq || state_nxt != state_r) begin
      dwell_r <= 8'h01;
    end else begin
      dwell_r <= dwell_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lenSample_r <= 6'h00;
      lenSettle_r <= 6'h00;
    end else begin
      if (startReq) begin
        lenSample_r <= sampleLen;
      end
      if (state_nxt == sarseq_pkg::ST_SETTLE && state_r != sarseq_pkg::ST_SETTLE) begin
        lenSettle_r <= settleLen;
      end
    end
  end

  assign convCycles = presc_r.divideByEight ? 8'h68 :
                      presc_r.divideByFour ? 8'h34 :
                      presc_r.divideByTwo ? 8'h1A : 8'h0D;

  sequence s_leaveSample;
    state_r == sarseq_pkg::ST_SAMPLE && state_nxt == sarseq_pkg::ST_SETTLE;
  endsequence

  sequence s_leaveSettle;
    state_r == sarseq_pkg::ST_SETTLE && state_nxt == sarseq_pkg::ST_CONV;
  endsequence

  sequence s_finish;
    done && !wrAcc;
  endsequence

  a_start_busy: assert property (
    startReq |=> state_r == sarseq_pkg::ST_SAMPLE ##0 busy)
    else $error("Start write did not begin a sampling phase.");

  a_zero_start: assert property (
    ctrlWr && !wrCtrl.start && !busy |=> !busy [*2])
    else $error("Writing zero to start began a conversion.");

  a_off_ignore: assert property (
    ctrlWr && !wrCtrl.converterEnable |=> !busy ##1 !irq_r)
    else $error("Conversion ran while the converter was disabled.");

  a_busy_read: assert property (
    setupPh && selCtrl |=> rdata_r[7] == $past(busy))
    else $error("Start bit read did not show the busy state.");

  a_sample_len: assert property (
    s_leaveSample |-> dwell_r == {2'h0, lenSample_r})
    else $error("Sampling phase length differs from the programmed value.");

  a_settle_len: assert property (
    s_leaveSettle |-> dwell_r == {2'h0, lenSettle_r})
    else $error("Settling phase length differs from the programmed value.");

  a_conv_length: assert property (
    s_finish ##0 $stable(presc_r) [*1] |-> dwell_r == convCycles)
    else $error("Conversion did not last thirteen converter clocks.");

  a_done_same: assert property (
    s_finish |=> irq_r && !busy && result_r == $past(syncB_r) ##1 !irq_r)
    else $error("Completion did not update, clear busy and pulse together.");

  a_result_hold: assert property (
    !irq_r |-> $stable(result_r))
    else $error("Result changed without a completed conversion.");

  a_low_latch: assert property (
    setupPh && !pwrite && selHigh |=> low_r == $past(result_r[1:0]))
    else $error("High byte read did not latch the matching low bits.");

endmodule : sar_adc_sequencer

// File: dv/sar_adc_sequencer_bench.sv
/*
  Self-checking bench for the converter sequencer: APB read and write tasks,
  a completion monitor that counts the phase cycles, and directed sequences.
  Assumes the design answers APB with zero wait states and that the
  analog result word is held steady by the bench across each conversion.
*/
`timescale 1ns/1ns
module sar_adc_sequencer_bench;
  logic clk;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic convDoneIrq;
  logic err;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [9:0] convResult;
  logic [9:0] res;
  logic [7:0] ctl;
  sarseq_pkg::sarseq_ana_type anaCtl;
  int n_fail = 0;
  int num_checks = 0;
  int cycleCnt = 0;
  int n, nSamp, nHold, nConv, nTick;

  sar_adc_sequencer DUT (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .convResult(convResult),
    .anaCtl(anaCtl),
    .convDoneIrq(convDoneIrq)
  );

  // The 25 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // A hang anywhere ends the run here instead of stalling the simulator.
  always @(posedge clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 6000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Byte address of a register index, and the prescale divisor by priority.
  function automatic logic [15:0] ba(input logic [13:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  function automatic int divOf(input logic [2:0] p);
    return p[2] ? 8 : (p[1] ? 4 : (p[0] ? 2 : 1));
  endfunction : divOf

  // Comparisons, one per kind of result.
  task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : chkData

  task automatic chkBit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask : chkBit

  task automatic chkCount(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      n_fail++;
      $display("Error at %0t: count %h expected %h", $time, got, exp);
    end
  endtask : chkCount

  // APB transfers; an idle cycle precedes each setup so no signal is driven twice at one edge.
  task automatic apbWrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= 1'b1;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbWrite

  task automatic apbRead(input logic [15:0] a, output logic [31:0] d, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= a;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbRead

  // Counts edges from the start to the completion pulse and the cycles of each
  // phase, beginning with the cycle that the start edge itself opens.
  task automatic waitIrq(input int limit);
    n = 0;
    nSamp = 0;
    nHold = 0;
    nConv = 0;
    nTick = 0;
    #1;
    do begin
      nSamp += int'(anaCtl.sampleOn === 1'b1);
      nHold += int'(anaCtl.holdOn === 1'b1);
      nConv += int'(anaCtl.convertOn === 1'b1);
      nTick += int'(anaCtl.conversionClockTick === 1'b1);
      @(posedge clk);
      #1;
      n++;
    end while (convDoneIrq !== 1'b1 && n < limit);
    // The last converter tick shows in the cycle of the completion pulse.
    nTick += int'(anaCtl.conversionClockTick === 1'b1);
  endtask : waitIrq

  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Main sequence: reset values, field masks, all channels and prescales, abort, refusals.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    convResult = 10'h000;
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    apbRead(ba(sarseq_pkg::IDX_CTRL), rd, err);
    chkData(rd, 32'h00000000);
    apbRead(ba(sarseq_pkg::IDX_SETTLE), rd, err);
    chkData(rd, 32'h0000000F);
    apbRead(ba(sarseq_pkg::IDX_SAMPLE), rd, err);
    chkData(rd, 32'h0000003F);
    apbRead(ba(sarseq_pkg::IDX_PRESC), rd, err);
    chkData(rd, 32'h00000000);
    apbRead(16'h3E00, rd, err);
    chkBit(err, 1'b1);
    chkData(rd, 32'h00000000);
    apbWrite(ba(sarseq_pkg::IDX_PRESC), 8'hFF);
    apbRead(ba(sarseq_pkg::IDX_PRESC), rd, err);
    chkData(rd, 32'h00000007);
    apbWrite(ba(sarseq_pkg::IDX_SETTLE), 8'hF3);
    apbRead(ba(sarseq_pkg::IDX_SETTLE), rd, err);
    chkData(rd, 32'h00000003);
    apbWrite(ba(sarseq_pkg::IDX_SAMPLE), 8'hC2);
    apbRead(ba(sarseq_pkg::IDX_SAMPLE), rd, err);
    chkData(rd, 32'h00000002);
    // Sample 2, settle 3; each pass uses another channel, reference and prescale code.
    for (int i = 0; i < 8; i++) begin
      res = 10'h3FF ^ 10'(i * 147);
      convResult <= res;
      ctl = 8'h10 | 8'(i) | (i[0] ? 8'h20 : 8'h00);
      apbWrite(ba(sarseq_pkg::IDX_PRESC), 8'(i));
      apbWrite(ba(sarseq_pkg::IDX_CTRL), ctl | 8'h80);
      waitIrq(400);
      chkCount(n, 5 + 13 * divOf(3'(i)));
      chkCount(nSamp, 2);
      chkCount(nHold, 3);
      chkCount(nConv, 13 * divOf(3'(i)));
      chkCount(nTick, 13);
      @(posedge clk);
      #1;
      chkBit(convDoneIrq, 1'b0);
      chkData({29'h0, anaCtl.inputChannelSelect}, 32'(i));
      chkBit(anaCtl.referenceBuffer, i[0]);
      chkBit(anaCtl.converterEnable, 1'b1);
      apbRead(ba(sarseq_pkg::IDX_CTRL), rd, err);
      chkData(rd, {24'h000000, ctl});
      convResult <= ~res;
      apbRead(ba(sarseq_pkg::IDX_HIGH), rd, err);
      chkData(rd, {24'h000000, res[9:2]});
      apbRead(ba(sarseq_pkg::IDX_LOW), rd, err);
      chkData(rd, {24'h000000, res[1:0], 6'h00});
    end
    // A second start during a run restarts the whole measurement.
    apbWrite(ba(sarseq_pkg::IDX_PRESC), 8'h00);
    apbWrite(ba(sarseq_pkg::IDX_CTRL), 8'h90);
    apbRead(ba(sarseq_pkg::IDX_CTRL), rd, err);
    chkData(rd, 32'h00000090);
    apbWrite(ba(sarseq_pkg::IDX_CTRL), 8'h90);
    waitIrq(400);
    chkCount(n, 18);
    // Start while disabled, and a zero written to start, both leave it idle.
    apbWrite(ba(sarseq_pkg::IDX_CTRL), 8'h80);
    apbRead(ba(sarseq_pkg::IDX_CTRL), rd, err);
    chkData(rd, 32'h00000000);
    waitIrq(100);
    chkBit(convDoneIrq, 1'b0);
    apbWrite(ba(sarseq_pkg::IDX_CTRL), 8'h10);
    apbRead(ba(sarseq_pkg::IDX_CTRL), rd, err);
    chkData(rd, 32'h00000010);
    waitIrq(100);
    chkBit(convDoneIrq, 1'b0);
    wrap_up();
  end
endmodule : sar_adc_sequencer_bench
